// ---- src/scg_top.sv ----
/*
 Clock gating control for run, sleep and deep-sleep operation, with a
 peripheral access checker that faults accesses to unclocked units.
 Assumes the power manager drives POWER_MODE and that peripheral
 address decoding supplies a one-hot unit select per access.
*/
// The Avalon-MM slave port was chosen for this implementation.
module scg_top
   import scg_pkg::*;
(
   input  wire logic                 REF_CLK,
   input  wire logic                 ARST_N,
   input  wire logic [9:0]           AVS_ADDRESS,
   input  wire logic                 AVS_READ,
   input  wire logic                 AVS_WRITE,
   input  wire logic [31:0]          AVS_WRITEDATA,
   input  wire logic [3:0]           AVS_BYTEENABLE,
   output logic      [31:0]          AVS_READDATA,
   output logic      [1:0]           AVS_RESPONSE,
   output logic                      AVS_WAITREQUEST,
   input  wire scg_pkg::scg_mode_type POWER_MODE,
   input  wire logic [3:0]           PERIPH_SEL,
   input  wire logic                 PERIPH_REQ,
   output logic                      PERIPH_FAULT,
   output logic      [3:0]           UNIT_CLK_EN,
   output logic      [1:0]           SAMPLE_RATE_SEL,
   output logic                      IRQ
);
   import scg_pkg::*;

   // Unit order in UNIT_CLK_EN: 0 watchdog, 1 timekeeper, 2 converter, 3 can
   typedef struct packed {
      logic [31:0] run_gate;
      logic [31:0] sleep_gate;
      logic [31:0] deep_gate;
      logic        auto_gate;
      logic [3:0]  clk_en;
      logic [1:0]  rate;
      logic        fault;
      logic [1:0]  irq_stat;
      logic [1:0]  irq_en;
      logic        ack;
      logic [31:0] rdata;
      logic [1:0]  resp;
   } scg_state_type;

   scg_state_type st_r;
   scg_state_type st_nxt;

   function automatic logic [31:0] merge_wr(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & GATE_WR_MASK;
      return (old & ~m) | (wd & m);
   endfunction : merge_wr

   function automatic logic [3:0] units(input logic [31:0] g);
      return {g[CAN_BIT], g[ADC_BIT], g[TIMEKEEP_BIT], g[WDOG_BIT]};
   endfunction : units

   logic [31:0] active_gate;
   logic        req;
   logic        fault_now;

   always_comb
   begin
      unique case (POWER_MODE)
         PM_SLEEP: active_gate = st_r.auto_gate ? st_r.sleep_gate : st_r.run_gate;
         PM_DEEP:  active_gate = st_r.auto_gate ? st_r.deep_gate : st_r.run_gate;
         default:  active_gate = st_r.run_gate;
      endcase
   end

   assign req       = (AVS_READ | AVS_WRITE) & ~st_r.ack;
   assign fault_now = PERIPH_REQ & |(PERIPH_SEL & ~st_r.clk_en);

   always_comb
   begin
      st_nxt        = st_r;
      st_nxt.ack    = req;
      st_nxt.resp   = 2'h0;
      st_nxt.rdata  = FAULT_DATA;
      st_nxt.clk_en = units(active_gate);
      st_nxt.rate   = active_gate[RATE_LSB +: 2];
      st_nxt.fault  = fault_now;
      // Set wins over a simultaneous clear
      if (req && AVS_WRITE && AVS_ADDRESS == IRQ_CLR_OFS)
         st_nxt.irq_stat = st_r.irq_stat & ~AVS_WRITEDATA[1:0];
      if (fault_now)
         st_nxt.irq_stat[0] = 1'b1;
      if (POWER_MODE != PM_RUN && !st_r.auto_gate)
         st_nxt.irq_stat[1] = 1'b1;
      if (req && AVS_WRITE)
      begin
         unique case (AVS_ADDRESS)
            RUN_GATE_OFS:   st_nxt.run_gate   = merge_wr(st_r.run_gate, AVS_WRITEDATA,
                                                         AVS_BYTEENABLE);
            SLEEP_GATE_OFS: st_nxt.sleep_gate = merge_wr(st_r.sleep_gate, AVS_WRITEDATA,
                                                         AVS_BYTEENABLE);
            DEEP_GATE_OFS:  st_nxt.deep_gate  = merge_wr(st_r.deep_gate, AVS_WRITEDATA,
                                                         AVS_BYTEENABLE);
            CLK_CFG_OFS:    if (AVS_BYTEENABLE[3])
                               st_nxt.auto_gate = AVS_WRITEDATA[AUTO_GATE_BIT];
            IRQ_EN_OFS:     if (AVS_BYTEENABLE[0])
                               st_nxt.irq_en = AVS_WRITEDATA[1:0];
            IRQ_STAT_OFS, IRQ_CLR_OFS: ;
            default:        st_nxt.resp = 2'h3;
         endcase
      end
      else if (req)
      begin
         unique case (AVS_ADDRESS)
            RUN_GATE_OFS:   st_nxt.rdata = st_r.run_gate;
            SLEEP_GATE_OFS: st_nxt.rdata = st_r.sleep_gate;
            DEEP_GATE_OFS:  st_nxt.rdata = st_r.deep_gate;
            CLK_CFG_OFS:    st_nxt.rdata = 32'(st_r.auto_gate) << AUTO_GATE_BIT;
            IRQ_STAT_OFS:   st_nxt.rdata = {30'h0, st_r.irq_stat};
            IRQ_EN_OFS:     st_nxt.rdata = {30'h0, st_r.irq_en};
            IRQ_CLR_OFS:    st_nxt.rdata = FAULT_DATA;
            default:        st_nxt.resp  = 2'h3;
         endcase
      end
   end

   always_ff @(posedge REF_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         st_r            <= '0;
         st_r.run_gate   <= GATE_RESET;
         st_r.sleep_gate <= GATE_RESET;
         st_r.deep_gate  <= GATE_RESET;
      end
      else
         st_r <= st_nxt;
   end

   // One wait cycle per access keeps read data registered
   assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~st_r.ack;
   assign AVS_READDATA    = st_r.rdata;
   assign AVS_RESPONSE    = st_r.resp;
   assign PERIPH_FAULT    = st_r.fault;
   assign UNIT_CLK_EN     = st_r.clk_en;
   assign SAMPLE_RATE_SEL = st_r.rate;
   assign IRQ             = |(st_r.irq_stat & st_r.irq_en);

   AST_RESET_GATE: assert property (@(posedge REF_CLK) $rose(ARST_N) |->
      st_r.sleep_gate == GATE_RESET) else $error("Sleep gate reset wrong");
   AST_RESERVED_ZERO: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (st_r.sleep_gate & ~GATE_WR_MASK) == 32'h0) else $error("Reserved bit set");
   AST_FAULT: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      fault_now |=> PERIPH_FAULT) else $error("Missing bus fault");
   AST_NO_FAULT: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      !PERIPH_REQ |=> !PERIPH_FAULT) else $error("Spurious fault");
   AST_SLEEP_SEL: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (POWER_MODE == PM_SLEEP && st_r.auto_gate) |=>
      UNIT_CLK_EN == units($past(st_r.sleep_gate))) else $error("Sleep pattern");
   AST_RUN_HOLD: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (POWER_MODE != PM_RUN && !st_r.auto_gate) |=>
      UNIT_CLK_EN == units($past(st_r.run_gate))) else $error("Run pattern");
   AST_CAN_BIT: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      POWER_MODE == PM_RUN |=> UNIT_CLK_EN[3] == $past(st_r.run_gate[CAN_BIT]))
      else $error("Can gate bit");
   AST_RATE: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      POWER_MODE == PM_RUN |=> SAMPLE_RATE_SEL == $past(st_r.run_gate[9:8]))
      else $error("Rate field");
   AST_WAIT_ONE: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      $rose(AVS_READ) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
      else $error("Wait length");

   // Pattern selection per mode
   AST_DEEP_SEL: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (POWER_MODE == PM_DEEP && st_r.auto_gate) |=>
      UNIT_CLK_EN == units($past(st_r.deep_gate))) else $error("Deep pattern");
   AST_RUN_SEL: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      POWER_MODE == PM_RUN |=> UNIT_CLK_EN == units($past(st_r.run_gate)))
      else $error("Run mode pattern");
   AST_RATE_SLEEP: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (POWER_MODE == PM_SLEEP && st_r.auto_gate) |=>
      SAMPLE_RATE_SEL == $past(st_r.sleep_gate[9:8])) else $error("Sleep rate");

   // Reserved bits can never be stored, whatever software writes
   AST_RESERVED_RUN: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (st_r.run_gate & ~GATE_WR_MASK) == 32'h0) else $error("Run reserved bit");
   AST_RESERVED_DEEP: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      (st_r.deep_gate & ~GATE_WR_MASK) == 32'h0) else $error("Deep reserved bit");

   // Reset values seen on the first edge after release
   AST_RESET_RUN: assert property (@(posedge REF_CLK) $rose(ARST_N) |->
      st_r.run_gate == GATE_RESET) else $error("Run gate reset wrong");
   AST_RESET_DEEP: assert property (@(posedge REF_CLK) $rose(ARST_N) |->
      st_r.deep_gate[TIMEKEEP_BIT]) else $error("Timekeeper not clocked");

   // Fault status is sticky and set in the cycle the fault is flagged
   AST_FAULT_STICKY: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      PERIPH_FAULT |-> st_r.irq_stat[0]) else $error("Fault status lost");
   AST_SET_WINS: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      fault_now |=> st_r.irq_stat[0]) else $error("Clear beat set");
   AST_WAIT_WRITE: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
      $rose(AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
      else $error("Write wait length");

   COV_FAULT: cover property (@(posedge REF_CLK) PERIPH_FAULT);
   COV_DEEP:  cover property (@(posedge REF_CLK) POWER_MODE == PM_DEEP && st_r.auto_gate);
   COV_RATE:  cover property (@(posedge REF_CLK) SAMPLE_RATE_SEL == RATE_500K);
   COV_SLEEP: cover property (@(posedge REF_CLK) POWER_MODE == PM_SLEEP && st_r.auto_gate);
   COV_IRQ:   cover property (@(posedge REF_CLK) IRQ);
endmodule : scg_top

// ---- src/scg_pkg.sv ----
/*
 Constants for the sleep-mode clock gating block: register offsets,
 field positions, reset values and the writable-bit mask.
 Assumes a 32-bit Avalon-MM slave port on a single 10 MHz clock.
*/
package scg_pkg;
   localparam logic [9:0]  RUN_GATE_OFS    = 10'h100;
   localparam logic [9:0]  SLEEP_GATE_OFS  = 10'h110;
   localparam logic [9:0]  DEEP_GATE_OFS   = 10'h120;
   localparam logic [9:0]  CLK_CFG_OFS     = 10'h060;
   localparam logic [9:0]  IRQ_STAT_OFS    = 10'h150;
   localparam logic [9:0]  IRQ_EN_OFS      = 10'h154;
   localparam logic [9:0]  IRQ_CLR_OFS     = 10'h158;
   localparam logic [31:0] GATE_RESET      = 32'h0000_0040;
   localparam logic [31:0] GATE_WR_MASK    = 32'h0101_0348;
   localparam int          CAN_BIT         = 24;
   localparam int          ADC_BIT         = 16;
   localparam int          RATE_LSB        = 8;
   localparam int          TIMEKEEP_BIT    = 6;
   localparam int          WDOG_BIT        = 3;
   localparam int          AUTO_GATE_BIT   = 27;
   localparam int          NUM_UNITS       = 4;
   localparam logic [1:0]  RATE_125K       = 2'h0;
   localparam logic [1:0]  RATE_250K       = 2'h1;
   localparam logic [1:0]  RATE_500K       = 2'h2;
   localparam logic [31:0] FAULT_DATA      = 32'h0000_0000;
   typedef enum logic [1:0] {
      PM_RUN   = 2'b00,
      PM_SLEEP = 2'b01,
      PM_DEEP  = 2'b10
   } scg_mode_type;
endpackage : scg_pkg

// ---- bench/testbench.sv ----
/*
 Self-checking bench for scg_top: register access, gate pattern per mode,
 converter rate field, faults on unclocked units and the interrupt.
 Assumes scg_pkg and scg_top are compiled first; one 10 MHz clock.
*/
module testbench
   import scg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic         ref_clk = 1'b0;
   logic         arst_n = 1'b0;
   logic [9:0]   adr = 10'h000;
   logic         rd_r = 1'b0;
   logic         wr_r = 1'b0;
   logic [31:0]  wdat = 32'h0;
   logic [31:0]  rdat;
   logic [1:0]   resp;
   logic         waitreq;
   scg_mode_type pmode = PM_RUN;
   logic [3:0]   psel = 4'h0;
   logic         preq = 1'b0;
   logic         pfault;
   logic [3:0]   clk_en;
   logic [1:0]   rate;
   logic         irq;
   int           mismatches = 0;
   int           cmp_count = 0;
   scg_top uut (.REF_CLK(ref_clk), .ARST_N(arst_n), .AVS_ADDRESS(adr), .AVS_READ(rd_r),
      .AVS_WRITE(wr_r), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
      .AVS_RESPONSE(resp), .AVS_WAITREQUEST(waitreq), .POWER_MODE(pmode), .PERIPH_SEL(psel),
      .PERIPH_REQ(preq), .PERIPH_FAULT(pfault), .UNIT_CLK_EN(clk_en),
      .SAMPLE_RATE_SEL(rate), .IRQ(irq));
   always #50 ref_clk = ~ref_clk;
   task report_and_stop;
      $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : report_and_stop
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         $display("BAD %s expected %h seen %h", what, exp, got);
         mismatches++;
      end
   endtask : chk
   // Request held until waitrequest is seen low; data taken in that cycle
   task bus(input logic w, input logic [9:0] a, input logic [31:0] d,
            output logic [31:0] x, output logic [1:0] r);
      int i;
      i = 0;
      @(posedge ref_clk);
      rd_r <= ~w; wr_r <= w; adr <= a; wdat <= d;
      do
      begin
         @(posedge ref_clk);
         i++;
      end while (waitreq !== 1'b0 && i < 20);
      if (waitreq !== 1'b0)
      begin
         chk("waitrequest", 32'h0, {31'h0, waitreq});
         report_and_stop();
      end
      x = rdat;
      r = resp;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
   endtask : bus
   task wr(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] x; logic [1:0] r;
      bus(1'b1, a, d, x, r);
      chk("write response", 32'h0, {30'h0, r});
   endtask : wr
   task rdc(input string what, input logic [9:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] x; logic [1:0] r;
      bus(1'b0, a, 32'h0, x, r);
      chk(what, e, x);
      chk("read response", {30'h0, er}, {30'h0, r});
   endtask : rdc
   // Enables are registered, so two edges pass before they are judged
   task setm(input scg_mode_type m, input logic [3:0] e);
      @(posedge ref_clk); pmode <= m;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk); chk("unit enables", {28'h0, e}, {28'h0, clk_en});
   endtask : setm
   task pulse(input logic [3:0] s, input logic ef, input logic ei);
      @(posedge ref_clk); psel <= s; preq <= 1'b1;
      @(posedge ref_clk); preq <= 1'b0;
      @(negedge ref_clk); chk("fault", {31'h0, ef}, {31'h0, pfault}); chk("irq", {31'h0, ei}, {31'h0, irq});
   endtask : pulse
   task t_regs;
      rdc("sleep gate", SLEEP_GATE_OFS, 32'h0000_0040, 2'h0);
      rdc("run gate", RUN_GATE_OFS, 32'h0000_0040, 2'h0);
      chk("reset enables", 32'h2, {28'h0, clk_en});
      wr(SLEEP_GATE_OFS, 32'hffff_ffff);
      rdc("sleep gate", SLEEP_GATE_OFS, 32'h0101_0348, 2'h0);
      rdc("deep gate", DEEP_GATE_OFS, 32'h0000_0040, 2'h0);
      rdc("unmapped", 10'h3fc, 32'h0, 2'h3);
      for (int k = 0; k < 3; k++)
      begin
         wr(RUN_GATE_OFS, 32'h0100_0008 | (k << 8));
         @(negedge ref_clk);
         chk("rate", k, {30'h0, rate});
         chk("run enables", 32'h9, {28'h0, clk_en});
      end
   endtask : t_regs
   task t_modes;
      wr(RUN_GATE_OFS, 32'h0001_0000);
      wr(SLEEP_GATE_OFS, 32'h0000_0008);
      wr(DEEP_GATE_OFS, 32'h0100_0000);
      setm(PM_SLEEP, 4'b0100);
      wr(CLK_CFG_OFS, 32'h0800_0000);
      rdc("auto gating", CLK_CFG_OFS, 32'h0800_0000, 2'h0);
      setm(PM_SLEEP, 4'b0001);
      setm(PM_DEEP, 4'b1000);
      setm(PM_RUN, 4'b0100);
      wr(CLK_CFG_OFS, 32'h0);
      setm(PM_DEEP, 4'b0100);
      setm(PM_RUN, 4'b0100);
   endtask : t_modes
   task t_fault;
      wr(IRQ_CLR_OFS, 32'h3);
      wr(IRQ_EN_OFS, 32'h1);
      pulse(4'b0100, 1'b0, 1'b0);
      pulse(4'b1000, 1'b1, 1'b1);
      rdc("status", IRQ_STAT_OFS, 32'h1, 2'h0);
      wr(IRQ_EN_OFS, 32'h0);
      chk("masked irq", 32'h0, {31'h0, irq});
      wr(IRQ_CLR_OFS, 32'h1);
      rdc("status", IRQ_STAT_OFS, 32'h0, 2'h0);
   endtask : t_fault
   initial
   begin
      repeat (6) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      t_regs();
      t_modes();
      t_fault();
      report_and_stop();
   end
endmodule : testbench
